// ==== scp_defs.vh ====
// Shared constants for the scan connect port: TAP state codes,
// global addresses, connect status codes and protocol lengths.
// Assumes it is included by bare name from every design file.
`ifndef SCP_DEFS_VH
`define SCP_DEFS_VH

// ==========================================================
// TAP state codes
`define SCP_TLR 4'h0
`define SCP_RTI 4'h1
`define SCP_SEL_DR 4'h2
`define SCP_CAP_DR 4'h3
`define SCP_SH_DR 4'h4
`define SCP_EX1_DR 4'h5
`define SCP_PA_DR 4'h6
`define SCP_EX2_DR 4'h7
`define SCP_UP_DR 4'h8
`define SCP_SEL_IR 4'h9
`define SCP_CAP_IR 4'ha
`define SCP_SH_IR 4'hb
`define SCP_EX1_IR 4'hc
`define SCP_PA_IR 4'hd
`define SCP_EX2_IR 4'he
`define SCP_UP_IR 4'hf

// ==========================================================
// Global addresses
`define SCP_ADDR_RESET 10'h000
`define SCP_ADDR_DISCONNECT 10'h3fe
`define SCP_ADDR_SYNC 10'h3ff

// ==========================================================
// Connect status codes
`define SCP_ST_OFF 2'h0
`define SCP_ST_ON 2'h1
`define SCP_ST_RESET 2'h2
`define SCP_ST_MCAST 2'h3

// ==========================================================
// Protocol lengths
`define SCP_ADDR_BITS 4'ha
`define SCP_ADDR_LONG 4'hb
`define SCP_ACK_HALVES 5'h1c
`define SCP_ACK_LAST_PAIR 4'hd

`endif

// ==== scp_tap_follower.v ====
// TAP state follower: steps the standard TAP state diagram.
// Assumes step is a one-cycle pulse per test clock rising edge.
`timescale 1ns/10ps
`default_nettype none
`include "scp_defs.vh"

module scp_tap_follower (
    input wire core_clk_i,
    input wire arst_n_i,
    input wire force_reset_i,
    input wire step_i,
    input wire mode_select_i,
    output reg [3:0] state_o
);

    reg [3:0] next_state;

    // ==========================================================
    // Next state
    always @* begin
        case (state_o)
            `SCP_TLR: next_state = mode_select_i ? `SCP_TLR : `SCP_RTI;
            `SCP_RTI: next_state = mode_select_i ? `SCP_SEL_DR : `SCP_RTI;
            `SCP_SEL_DR: next_state = mode_select_i ? `SCP_SEL_IR : `SCP_CAP_DR;
            `SCP_CAP_DR: next_state = mode_select_i ? `SCP_EX1_DR : `SCP_SH_DR;
            `SCP_SH_DR: next_state = mode_select_i ? `SCP_EX1_DR : `SCP_SH_DR;
            `SCP_EX1_DR: next_state = mode_select_i ? `SCP_UP_DR : `SCP_PA_DR;
            `SCP_PA_DR: next_state = mode_select_i ? `SCP_EX2_DR : `SCP_PA_DR;
            `SCP_EX2_DR: next_state = mode_select_i ? `SCP_UP_DR : `SCP_SH_DR;
            `SCP_UP_DR: next_state = mode_select_i ? `SCP_SEL_DR : `SCP_RTI;
            `SCP_SEL_IR: next_state = mode_select_i ? `SCP_TLR : `SCP_CAP_IR;
            `SCP_CAP_IR: next_state = mode_select_i ? `SCP_EX1_IR : `SCP_SH_IR;
            `SCP_SH_IR: next_state = mode_select_i ? `SCP_EX1_IR : `SCP_SH_IR;
            `SCP_EX1_IR: next_state = mode_select_i ? `SCP_UP_IR : `SCP_PA_IR;
            `SCP_PA_IR: next_state = mode_select_i ? `SCP_EX2_IR : `SCP_PA_IR;
            `SCP_EX2_IR: next_state = mode_select_i ? `SCP_UP_IR : `SCP_SH_IR;
            `SCP_UP_IR: next_state = mode_select_i ? `SCP_SEL_DR : `SCP_RTI;
            default: next_state = `SCP_TLR;
        endcase
    end

    // ==========================================================
    // State register
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_o <= `SCP_TLR;
        end else if (force_reset_i) begin
            state_o <= `SCP_TLR;
        end else if (step_i) begin
            state_o <= next_state;
        end
    end

endmodule // scp_tap_follower
`default_nettype wire

// ==== scp_connect.v ====
// Connect control of a multidrop addressable scan port: TAP monitors,
// shadow address receiver, address decode, acknowledge and the switch.
// Assumes all port pins are asynchronous to core_clk_i, and the test
// clock is much slower than core_clk_i so its edges can be sampled.
`timescale 1ns/10ps
`default_nettype none
`include "scp_defs.vh"

// What this block does
// - No shadow reception or response while primary state is Shift-DR.
// - No shadow reception or response in Exit1-DR or Exit2-DR.
// - Pause-DR accepts shadow sequences and recognises the sync address.
// - No shadow reception or response in Update-DR.
// - No shadow reception or response in any IR state but Pause-IR.
// - Pause-IR accepts shadow sequences and recognises the sync address.
// - Status comes from last valid address against board and globals.
// - All-zero address gives RESET status.
// - Address 3fe gives DISCONNECT result and OFF status.
// - All-ones address gives MULTICAST status when both followers sit in a Pause state.
// - Board match sends acknowledge, then enters ON with full connection.
// - Other addresses give OFF at once: outputs off, select held.
// - Disconnect gives OFF at once, no acknowledge, chain state kept.
// - Reset gives RESET at once: outputs off, secondary select high.
// - Sync gives MULTICAST: data and select forward, primary out off.
// - Sync takes effect only when both followers sit in a Pause state.
// - Sync outside both Pause states is treated as DISCONNECT.
// - Symbols are bit pairs: idle 11, select 00, one 01, zero 10.
// - Ten data pairs, LSB first, framed IS ... SI, also for acknowledge.
// - Primary monitor follows TAP diagram on mode select at clock rise.
// - Connect indicator low for MATCH or sync, high during acknowledge.
module scp_connect (
    input wire core_clk_i,
    input wire arst_n_i,
    input wire primary_test_clock_i,
    input wire primary_data_in_i,
    input wire primary_mode_select_i,
    input wire primary_test_reset_n_i,
    input wire protocol_bypass_n_i,
    input wire secondary_data_in_i,
    input wire [9:0] board_address_inputs_i,
    output reg primary_data_out_o,
    output reg primary_data_out_oe_o,
    output reg secondary_data_out_o,
    output reg secondary_data_out_oe_o,
    output reg secondary_mode_select_o,
    output reg connect_indicator_n_o
);

    localparam RX_IDLE = 3'h0;
    localparam RX_SEL = 3'h1;
    localparam RX_PAIR_A = 3'h2;
    localparam RX_PAIR_B = 3'h3;
    localparam RX_CLOSE_A = 3'h4;
    localparam RX_CLOSE_B = 3'h5;

    // ==========================================================
    // Input synchronisers
    reg [1:0] sync_tck, sync_tdi, sync_tms, sync_trst, sync_byp, sync_sdi;
    reg [9:0] sync_addr_a, board_addr;
    reg tck_prev;
    wire tck, tdi, tms, trst_n, byp_n, sdi, tck_rise;

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync_tck <= 2'h0;
            sync_tdi <= 2'h3;
            sync_tms <= 2'h3;
            sync_trst <= 2'h0;
            sync_byp <= 2'h3;
            sync_sdi <= 2'h3;
            sync_addr_a <= 10'h000;
            board_addr <= 10'h000;
            tck_prev <= 1'b0;
        end else begin
            sync_tck <= {sync_tck[0], primary_test_clock_i};
            sync_tdi <= {sync_tdi[0], primary_data_in_i};
            sync_tms <= {sync_tms[0], primary_mode_select_i};
            sync_trst <= {sync_trst[0], primary_test_reset_n_i};
            sync_byp <= {sync_byp[0], protocol_bypass_n_i};
            sync_sdi <= {sync_sdi[0], secondary_data_in_i};
            sync_addr_a <= board_address_inputs_i;
            board_addr <= sync_addr_a;
            tck_prev <= sync_tck[1];
        end
    end

    assign tck = sync_tck[1];
    assign tdi = sync_tdi[1];
    assign tms = sync_tms[1];
    assign trst_n = sync_trst[1];
    assign byp_n = sync_byp[1];
    assign sdi = sync_sdi[1];
    assign tck_rise = tck & ~tck_prev;

    // ==========================================================
    // TAP state followers
    wire [3:0] prim_state, sec_state;
    wire prim_pause, sec_pause, prim_ok;

    scp_tap_follower u_prim (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .force_reset_i(~trst_n),
        .step_i(tck_rise),
        .mode_select_i(tms),
        .state_o(prim_state)
    );

    scp_tap_follower u_sec (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .force_reset_i(1'b0),
        .step_i(tck_rise),
        .mode_select_i(secondary_mode_select_o),
        .state_o(sec_state)
    );

    assign prim_pause = (prim_state == `SCP_PA_DR) ||
                        (prim_state == `SCP_PA_IR);
    assign sec_pause = (sec_state == `SCP_PA_DR) ||
                       (sec_state == `SCP_PA_IR);
    // Only the four stable non-shift states accept shadow traffic
    assign prim_ok = prim_pause || (prim_state == `SCP_TLR) ||
                     (prim_state == `SCP_RTI);

    // ==========================================================
    // Shadow receiver, decode and acknowledge
    reg [2:0] rx_state;
    reg rx_armed, rx_first;
    reg [3:0] rx_cnt;
    reg [9:0] rx_addr;
    reg rx_all_one, rx_all_zero;
    reg [3:0] rx_start;
    reg [1:0] status;
    reg ack_busy;
    reg [4:0] ack_half;
    reg [3:0] ack_start;
    wire rx_hold, rx_bad, pair_one, pair_zero, pair_sel, pair_idle;
    wire [3:0] ack_pair, ack_idx;
    reg ack_bit;

    assign rx_hold = ~trst_n | ~byp_n;
    // A state change or a disabled state while framing aborts the frame
    assign rx_bad = (rx_state != RX_IDLE) &&
                    (!prim_ok || prim_state != rx_start);
    assign pair_one = ~rx_first & tdi;
    assign pair_zero = rx_first & ~tdi;
    assign pair_sel = ~rx_first & ~tdi;
    assign pair_idle = rx_first & tdi;
    assign ack_pair = ack_half[4:1];
    assign ack_idx = ack_pair - 4'h2;

    // Acknowledge bit: I S D0..D9 S I, each as a half pair
    always @* begin
        if (ack_pair == 4'h0 || ack_pair == `SCP_ACK_LAST_PAIR) begin
            ack_bit = 1'b1;
        end else if (ack_pair == 4'h1 || ack_pair == 4'hc) begin
            ack_bit = 1'b0;
        end else begin
            ack_bit = rx_addr[ack_idx] ^ ~ack_half[0];
        end
    end

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_state <= RX_IDLE;
            rx_armed <= 1'b0;
            rx_first <= 1'b0;
            rx_cnt <= 4'h0;
            rx_addr <= 10'h000;
            rx_all_one <= 1'b1;
            rx_all_zero <= 1'b1;
            rx_start <= `SCP_TLR;
            status <= `SCP_ST_OFF;
            ack_busy <= 1'b0;
            ack_half <= 5'h00;
            ack_start <= `SCP_TLR;
        end else if (rx_hold) begin
            rx_state <= RX_IDLE;
            rx_armed <= 1'b0;
            ack_busy <= 1'b0;
        end else if (tck_rise && ack_busy) begin
            if (prim_state != ack_start) begin
                ack_busy <= 1'b0;
                status <= `SCP_ST_OFF;
            end else if (ack_half == `SCP_ACK_HALVES - 5'h01) begin
                ack_busy <= 1'b0;
                status <= `SCP_ST_ON;
            end else begin
                ack_half <= ack_half + 5'h01;
            end
        end else if (tck_rise && rx_bad) begin
            rx_state <= RX_IDLE;
            rx_armed <= 1'b0;
            if (rx_cnt != 4'h0) begin
                status <= `SCP_ST_OFF;
            end
        end else if (tck_rise && prim_ok) begin
            case (rx_state)
                RX_IDLE: begin
                    rx_armed <= tdi;
                    if (rx_armed && !tdi) begin
                        rx_state <= RX_SEL;
                        rx_start <= prim_state;
                    end
                end
                RX_SEL: begin
                    rx_armed <= tdi;
                    rx_cnt <= 4'h0;
                    rx_all_one <= 1'b1;
                    rx_all_zero <= 1'b1;
                    rx_state <= tdi ? RX_IDLE : RX_PAIR_A;
                end
                RX_PAIR_A: begin
                    rx_first <= tdi;
                    rx_state <= RX_PAIR_B;
                end
                RX_PAIR_B: begin
                    if (pair_one || pair_zero) begin
                        // LSB arrives first, so shift in from the top
                        if (rx_cnt < `SCP_ADDR_BITS) begin
                            rx_addr <= {pair_one, rx_addr[9:1]};
                        end
                        if (rx_cnt != `SCP_ADDR_LONG) begin
                            rx_cnt <= rx_cnt + 4'h1;
                        end
                        rx_all_one <= rx_all_one & pair_one;
                        rx_all_zero <= rx_all_zero & pair_zero;
                        rx_state <= RX_PAIR_A;
                    end else if (pair_sel) begin
                        rx_state <= (rx_cnt == 4'h0) ? RX_PAIR_A : RX_CLOSE_A;
                    end else begin
                        rx_state <= RX_IDLE;
                        rx_armed <= 1'b1;
                        if (rx_cnt != 4'h0) begin
                            status <= `SCP_ST_OFF;
                        end
                    end
                end
                RX_CLOSE_A: begin
                    rx_first <= tdi;
                    rx_state <= RX_CLOSE_B;
                end
                RX_CLOSE_B: begin
                    rx_state <= RX_IDLE;
                    rx_armed <= 1'b1;
                    if (!pair_idle) begin
                        status <= `SCP_ST_OFF;
                    end else if (rx_cnt == `SCP_ADDR_LONG) begin
                        // Long runs of all ones or zeros keep global meaning
                        if (rx_all_zero) begin
                            status <= `SCP_ST_RESET;
                        end else if (rx_all_one && prim_pause && sec_pause) begin
                            status <= `SCP_ST_MCAST;
                        end else begin
                            status <= `SCP_ST_OFF;
                        end
                    end else if (rx_cnt != `SCP_ADDR_BITS) begin
                        status <= `SCP_ST_OFF;
                    end else if (rx_addr == `SCP_ADDR_RESET) begin
                        status <= `SCP_ST_RESET;
                    end else if (rx_addr == `SCP_ADDR_DISCONNECT) begin
                        status <= `SCP_ST_OFF;
                    end else if (rx_addr == `SCP_ADDR_SYNC) begin
                        if (prim_pause && sec_pause) begin
                            status <= `SCP_ST_MCAST;
                        end else begin
                            status <= `SCP_ST_OFF;
                        end
                    end else if (rx_addr == board_addr) begin
                        status <= `SCP_ST_OFF;
                        ack_busy <= 1'b1;
                        ack_half <= 5'h00;
                        ack_start <= prim_state;
                    end else begin
                        status <= `SCP_ST_OFF;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Switch and connect indicator
    reg next_pdo, next_pdo_oe, next_sdo, next_sdo_oe, next_secondary_mode_select, next_con_n;

    always @* begin
        next_pdo = sdi;
        next_pdo_oe = 1'b0;
        next_sdo = tdi;
        next_sdo_oe = 1'b0;
        next_secondary_mode_select = secondary_mode_select_o;
        next_con_n = 1'b1;
        if (!byp_n) begin
            next_pdo_oe = 1'b1;
            next_sdo_oe = 1'b1;
            next_secondary_mode_select = trst_n ? tms : 1'b1;
            next_con_n = 1'b0;
        end else if (!trst_n) begin
            next_secondary_mode_select = 1'b1;
        end else if (ack_busy) begin
            next_pdo = ack_bit;
            next_pdo_oe = 1'b1;
        end else begin
            case (status)
                `SCP_ST_ON: begin
                    next_pdo_oe = 1'b1;
                    next_sdo_oe = 1'b1;
                    next_secondary_mode_select = tms;
                    next_con_n = 1'b0;
                end
                `SCP_ST_MCAST: begin
                    next_sdo_oe = 1'b1;
                    next_secondary_mode_select = tms;
                    next_con_n = 1'b0;
                end
                `SCP_ST_RESET: begin
                    next_secondary_mode_select = 1'b1;
                end
                default: begin
                    next_secondary_mode_select = secondary_mode_select_o;
                end
            endcase
        end
    end

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            primary_data_out_o <= 1'b1;
            primary_data_out_oe_o <= 1'b0;
            secondary_data_out_o <= 1'b1;
            secondary_data_out_oe_o <= 1'b0;
            secondary_mode_select_o <= 1'b1;
            connect_indicator_n_o <= 1'b1;
        end else begin
            primary_data_out_o <= next_pdo;
            primary_data_out_oe_o <= next_pdo_oe;
            secondary_data_out_o <= next_sdo;
            secondary_data_out_oe_o <= next_sdo_oe;
            secondary_mode_select_o <= next_secondary_mode_select;
            connect_indicator_n_o <= next_con_n;
        end
    end

endmodule // scp_connect
`default_nettype wire

// ==== scp_connect_checker.sv ====
// Concurrent checks on the outputs of the scan connect port.
// Assumes binding to scp_connect, with a 3-cycle pass-through latency.
`timescale 1ns/10ps
`default_nettype none
module scp_connect_checker (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic primary_data_in_i,
    input wire logic primary_mode_select_i,
    input wire logic secondary_data_in_i,
    input wire logic primary_data_out_o,
    input wire logic primary_data_out_oe_o,
    input wire logic secondary_data_out_o,
    input wire logic secondary_data_out_oe_o,
    input wire logic secondary_mode_select_o,
    input wire logic connect_indicator_n_o
);
    logic ack;
    logic on;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // Only the acknowledge drives the primary output without the secondary
    assign ack = primary_data_out_oe_o && !secondary_data_out_oe_o;
    assign on = !connect_indicator_n_o;
    // ==========================================================
    // Assertions
    a_ack_con_high: assert property (ack |-> connect_indicator_n_o)
        else $error("indicator low during acknowledge");
    a_ack_idle_first: assert property ($rose(ack) |-> primary_data_out_o)
        else $error("acknowledge does not open high");
    a_ack_bounded: assert property ($rose(ack) |-> ##[1:600] !ack)
        else $error("acknowledge does not end");
    a_off_no_drive: assert property (!on |-> !secondary_data_out_oe_o)
        else $error("secondary output driven while disconnected");
    a_on_drives: assert property (on |-> secondary_data_out_oe_o)
        else $error("secondary output idle while connected");
    a_off_select_held: assert property (!secondary_data_out_oe_o &&
        $past(!secondary_data_out_oe_o) |-> !$fell(secondary_mode_select_o))
        else $error("secondary select dropped while off");
    a_fwd_data: assert property (on [*5] |->
        secondary_data_out_o == $past(primary_data_in_i, 3))
        else $error("secondary data not forwarded");
    a_fwd_select: assert property (on [*5] |->
        secondary_mode_select_o == $past(primary_mode_select_i, 3))
        else $error("secondary select not forwarded");
    a_return_data: assert property ((on && primary_data_out_oe_o) [*5] |->
        primary_data_out_o == $past(secondary_data_in_i, 3))
        else $error("primary data not returned");
endmodule // scp_connect_checker

bind scp_connect scp_connect_checker u_chk (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .primary_data_in_i(primary_data_in_i),
    .primary_mode_select_i(primary_mode_select_i),
    .secondary_data_in_i(secondary_data_in_i),
    .primary_data_out_o(primary_data_out_o),
    .primary_data_out_oe_o(primary_data_out_oe_o),
    .secondary_data_out_o(secondary_data_out_o),
    .secondary_data_out_oe_o(secondary_data_out_oe_o),
    .secondary_mode_select_o(secondary_mode_select_o),
    .connect_indicator_n_o(connect_indicator_n_o)
);
`default_nettype wire

// ==== scp_master_model.sv ====
// Bus master model on the primary test port: TAP moves and frames.
// Assumes a 10 ns core clock; the test clock stands low between calls.
`timescale 1ns/10ps
`default_nettype none
module scp_master_model (
    input wire logic core_clk_i,
    input wire logic primary_data_out_i,
    output logic primary_test_clock_o,
    output logic primary_data_in_o,
    output logic primary_mode_select_o
);
    logic [27:0] ack_seen;
    initial begin
        primary_test_clock_o = 1'b0;
        primary_data_in_o = 1'b1;
        primary_mode_select_o = 1'b0;
        ack_seen = 28'h0000000;
    end
    // ==========================================================
    // One 160 ns test clock period; returned data sampled before the rise
    task automatic cyc(input logic ms, input logic di);
        @(negedge core_clk_i);
        primary_mode_select_o = ms;
        primary_data_in_o = di;
        repeat (7) @(negedge core_clk_i);
        ack_seen = {primary_data_out_i, ack_seen[27:1]};
        primary_test_clock_o = 1'b1;
        repeat (8) @(negedge core_clk_i);
        primary_test_clock_o = 1'b0;
    endtask
    task automatic moves(input logic [7:0] tms, input int n);
        for (int i = 0; i < n; i++)
            cyc(tms[i], 1'b1);
    endtask
    // Frame I S D0..D9 S I, then idle clocks for the acknowledge
    task automatic frame(input logic [9:0] a, input int ack_n);
        cyc(1'b0, 1'b1);
        cyc(1'b0, 1'b1);
        cyc(1'b0, 1'b0);
        cyc(1'b0, 1'b0);
        for (int i = 0; i < 10; i++) begin
            cyc(1'b0, ~a[i]);
            cyc(1'b0, a[i]);
        end
        cyc(1'b0, 1'b0);
        cyc(1'b0, 1'b0);
        cyc(1'b0, 1'b1);
        cyc(1'b0, 1'b1);
        for (int i = 0; i < ack_n; i++)
            cyc(1'b0, 1'b1);
    endtask
endmodule // scp_master_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for scp_connect with a bus master model.
// Assumes bypass and test reset stay inactive throughout.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk, arst_n, primary_test_clock, pdi, pms, sdi;
    logic pdo, pdo_oe, sdo, sdo_oe, secondary_mode_select, con_n;
    logic [9:0] board_addr;
    wire pdo_line;
    int n_fail, samples_checked;
    // Pull-up on the primary output line
    assign pdo_line = pdo_oe ? pdo : 1'b1;
    scp_connect uut (
        .core_clk_i(clk),
        .arst_n_i(arst_n),
        .primary_test_clock_i(primary_test_clock),
        .primary_data_in_i(pdi),
        .primary_mode_select_i(pms),
        .primary_test_reset_n_i(1'b1),
        .protocol_bypass_n_i(1'b1),
        .secondary_data_in_i(sdi),
        .board_address_inputs_i(board_addr),
        .primary_data_out_o(pdo),
        .primary_data_out_oe_o(pdo_oe),
        .secondary_data_out_o(sdo),
        .secondary_data_out_oe_o(sdo_oe),
        .secondary_mode_select_o(secondary_mode_select),
        .connect_indicator_n_o(con_n)
    );
    scp_master_model m (
        .core_clk_i(clk),
        .primary_data_out_i(pdo_line),
        .primary_test_clock_o(primary_test_clock),
        .primary_data_in_o(pdi),
        .primary_mode_select_o(pms)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) sdi <= ~sdi;
    // ==========================================================
    // Compare tasks
    task automatic chk_out(input logic [3:0] exp);
        samples_checked++;
        if ({pdo_oe, sdo_oe, con_n, secondary_mode_select} !== exp) begin
            n_fail++;
            $display("mismatch at %0t: outputs %b want %b", $time,
                {pdo_oe, sdo_oe, con_n, secondary_mode_select}, exp);
        end
    endtask
    task automatic chk_ack(input logic [27:0] exp);
        samples_checked++;
        if (m.ack_seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: ack %h want %h", $time, m.ack_seen, exp);
        end
    endtask
    function automatic logic [27:0] ack_exp(input logic [9:0] a);
        logic [27:0] e;
        e = 28'hc000003;
        for (int i = 0; i < 10; i++) begin
            e[4 + 2 * i] = ~a[i];
            e[5 + 2 * i] = a[i];
        end
        return e;
    endfunction
    task automatic wrap_up;
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ==========================================================
    // Scenarios; expected order is {pdo_oe, sdo_oe, con_n, secondary_mode_select}
    task automatic s_nomatch;
        m.frame(10'h155, 0);
        chk_out(4'b0011);
    endtask
    task automatic s_match;
        m.frame(board_addr, 28);
        chk_ack(ack_exp(board_addr));
        chk_out(4'b1100);
    endtask
    task automatic s_disconnect;
        m.frame(10'h3fe, 0);
        chk_out(4'b0010);
    endtask
    task automatic s_reset;
        m.frame(10'h000, 0);
        chk_out(4'b0011);
    endtask
    task automatic s_sync_pause;
        m.frame(10'h3ff, 0);
        chk_out(4'b0100);
    endtask
    task automatic s_pause_ir;
        m.frame(10'h155, 0);
        chk_out(4'b0010);
        m.frame(10'h3ff, 0);
        chk_out(4'b0100);
    endtask
    task automatic s_sync_idle;
        m.frame(10'h3ff, 0);
        chk_out(4'b0010);
    endtask
    task automatic s_shift_ignored;
        m.frame(10'h3fe, 0);
        chk_out(4'b1100);
    endtask
    // Park the chain in Pause-DR, roam the primary, then sync it back
    task automatic s_park;
        m.moves(8'h01, 2);
        m.frame(10'h3fe, 0);
        chk_out(4'b0010);
        m.moves(8'h2b, 7);
        m.frame(10'h3ff, 0);
        chk_out(4'b0100);
    endtask
    initial begin
        arst_n = 1'b0;
        sdi = 1'b0;
        board_addr = 10'h2a5;
        n_fail = 0;
        samples_checked = 0;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk_out(4'b0011);
        m.moves(8'h00, 1);
        s_nomatch;
        s_match;
        s_disconnect;
        s_reset;
        s_match;
        // Leading idle clock takes the chain from reset along with us
        m.moves(8'h0a, 5);
        s_sync_pause;
        m.moves(8'h2f, 7);
        s_pause_ir;
        m.moves(8'h03, 3);
        s_sync_idle;
        s_match;
        m.moves(8'h01, 3);
        s_shift_ignored;
        s_park;
        wrap_up;
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        $display("mismatch at %0t: run did not finish", $time);
        wrap_up;
    end
endmodule // tb
`default_nettype wire
